// *** hdl/nspm_regs.vh ***
// Register map, field positions, reset values and timing counts of the power manager
//Contract
//- Host sets hold-pin enable bit 4 of 0x05; while clear the hold pin is ignored.
//- Host-managed mode, hold enabled: hold pin high enters the low-power hold state.
//- Self-managed mode, hold enabled: hold pin high disables the I2C interface.
//- Movement flag is push-pull or open-drain with programmable active level.
//- Orientation register 0x27 resets to 0x08: axis exchange set, no reversal.
//- Writes to 0x27 reverse X, reverse Y or exchange axes of motion data.
//- After boot enter software idle, then host-managed or self-managed run once configured.
//- Host-managed run persists until I2C idle command, hold pin or supply-off pin.
//- Host-managed run never enters low power on its own, even without motion.
//- Self-managed run moves autonomously into low-power states by motion activity.
//- Hold in host-managed run finishes current frame, then stops clock; at most 1 ms.
//- In hold, clock and motion engine off; no I2C response, no motion detection; the flag still follows motionSeen in hold.
//- Registers kept in hold; release resumes run at once without re-initialization.
//- Supply-off high removes core power; release causes reset, reboot, idle, config lost.
//- Power-up delays: 20 us reset, 1 us clock startup, 450 us controller boot.
//- Flag pin driven 1 at software idle after boot, low once in run.
//- With active-low flag polarity selected, the pin stays high when entering run.
//- Self-managed mode with hold enabled: pin is an active-low I2C chip select.
`ifndef NSPM_REGS_VH
`define NSPM_REGS_VH
`define NSPM_ADDR_SYSTEM_SETUP 8'h05
`define NSPM_ADDR_ORIENTATION 8'h27
`define NSPM_ADDR_COMMAND 8'h06
`define NSPM_RST_SYSTEM_SETUP 8'h00
`define NSPM_RST_ORIENTATION 8'h08
`define NSPM_BIT_RUN_REQ 0
`define NSPM_BIT_SELF_MODE 1
`define NSPM_BIT_FLAG_ACTLOW 2
`define NSPM_BIT_FLAG_OPENDRAIN 3
`define NSPM_BIT_HOLD_EN 4
`define NSPM_BIT_REV_X 0
`define NSPM_BIT_REV_Y 1
`define NSPM_BIT_EXCHANGE 3
`define NSPM_CMD_IDLE 8'h01
`define NSPM_CLK_MHZ 50
`define NSPM_POR_US 20
`define NSPM_CLKUP_US 1
`define NSPM_BOOT_US 450
`define NSPM_POR_CYC (`NSPM_POR_US * `NSPM_CLK_MHZ)
`define NSPM_CLKUP_CYC (`NSPM_CLKUP_US * `NSPM_CLK_MHZ)
`define NSPM_BOOT_CYC (`NSPM_BOOT_US * `NSPM_CLK_MHZ)
`define NSPM_FRAME_US 1000
`define NSPM_FRAME_CYC (`NSPM_FRAME_US * `NSPM_CLK_MHZ)
`define NSPM_IDLE_FRAMES 8
`endif

// *** hdl/nspm_power_manager.v ***
// Power-state sequencer of the finger-navigation sensor
`include "nspm_regs.vh"
module nspm_power_manager #(
    parameter BOOT_CYC = `NSPM_BOOT_CYC,
    parameter FRAME_CYC = `NSPM_FRAME_CYC
) (
    input wire mclk,
    input wire rst,
    input wire clkEn,
    input wire holdPin,
    input wire supplyOffPin,
    input wire regWrite,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    input wire motionSeen,
    input wire signed [7:0] rawDx,
    input wire signed [7:0] rawDy,
    output reg signed [7:0] outDx,
    output reg signed [7:0] outDy,
    output reg flagOut,
    output reg flagOe,
    output reg i2cEnable,
    output reg engineEnable,
    output reg coreClockRun,
    output reg corePowerOn,
    output reg [7:0] powerState
);
    localparam ST_OFF = 8'h01;
    localparam ST_POR = 8'h02;
    localparam ST_CLKUP = 8'h04;
    localparam ST_BOOT = 8'h08;
    localparam ST_IDLE = 8'h10;
    localparam ST_HRUN = 8'h20;
    localparam ST_SRUN = 8'h40;
    localparam ST_HOLD = 8'h80;
    localparam [7:0] SLEEP_SEL = 8'h01;

    reg hold1, hold2, off1, off2;
    reg [7:0] state;
    reg [31:0] cnt;
    reg [31:0] frameCnt;
    reg [7:0] systemSetup;
    reg [7:0] orientation;
    reg holdPending;
    reg [3:0] quietFrames;
    reg selfSleep;
    reg flagReady;
    reg [7:0] next_state;

    wire frameEnd;
    wire holdEn;
    wire selfMode;
    wire actLow;
    wire openDrain;
    wire holdReq;
    wire busOpen;
    wire wr;
    wire idleCmd;
    wire runReq;
    wire flagActive;
    wire [15:0] rawPair;
    wire [15:0] orientedPair;

    assign frameEnd = (frameCnt == FRAME_CYC - 1);
    assign holdEn = systemSetup[`NSPM_BIT_HOLD_EN];
    assign selfMode = systemSetup[`NSPM_BIT_SELF_MODE];
    assign actLow = systemSetup[`NSPM_BIT_FLAG_ACTLOW];
    assign openDrain = systemSetup[`NSPM_BIT_FLAG_OPENDRAIN];
    assign holdReq = hold2 & holdEn;
    assign busOpen = (state == ST_IDLE) | (state == ST_HRUN) |
                     ((state == ST_SRUN) & ~(holdEn & hold2));
    assign wr = regWrite & busOpen;
    assign idleCmd = wr & (regAddr == `NSPM_ADDR_COMMAND) & (regWdata == `NSPM_CMD_IDLE);
    assign runReq = systemSetup[`NSPM_BIT_RUN_REQ];
    assign flagActive = flagReady | motionSeen;
    assign rawPair = {rawDy, rawDx};

    // Pin synchronisers: two flops before use
    always @(posedge mclk) begin
        if (rst) begin
            hold1 <= 1'b0;
            hold2 <= 1'b0;
            off1 <= 1'b0;
            off2 <= 1'b0;
        end else if (clkEn) begin
            hold1 <= holdPin;
            hold2 <= hold1;
            off1 <= supplyOffPin;
            off2 <= off1;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (!off2) next_state = ST_POR;
            end
            ST_POR: begin
                if (cnt == `NSPM_POR_CYC - 1) next_state = ST_CLKUP;
            end
            ST_CLKUP: begin
                if (cnt == `NSPM_CLKUP_CYC - 1) next_state = ST_BOOT;
            end
            ST_BOOT: begin
                if (cnt == BOOT_CYC - 1) next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (runReq) next_state = selfMode ? ST_SRUN : ST_HRUN;
            end
            ST_HRUN: begin
                if (idleCmd) next_state = ST_IDLE;
                else if (holdPending && frameEnd) next_state = ST_HOLD;
            end
            ST_SRUN: begin
                if (idleCmd) next_state = ST_IDLE;
            end
            ST_HOLD: begin
                if (!holdReq) next_state = ST_HRUN;
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (off2) next_state = ST_OFF;
    end

    // State and step counter
    always @(posedge mclk) begin
        if (rst) begin
            state <= ST_OFF;
            cnt <= 32'h0000_0000;
        end else if (clkEn) begin
            state <= next_state;
            if (next_state != state)
                cnt <= 32'h0000_0000;
            else
                cnt <= cnt + 32'h0000_0001;
        end
    end

    // Frame counter frozen in hold so the frame resumes where it stopped
    always @(posedge mclk) begin
        if (rst) begin
            frameCnt <= 32'h0000_0000;
            holdPending <= 1'b0;
        end else if (clkEn) begin
            if (state == ST_HRUN || state == ST_SRUN)
                frameCnt <= frameEnd ? 32'h0000_0000 : frameCnt + 32'h0000_0001;
            else if (state != ST_HOLD)
                frameCnt <= 32'h0000_0000;
            // Pending hold survives until frame end or release
            if (state == ST_HRUN && holdReq)
                holdPending <= 1'b1;
            else if (!holdReq || state != ST_HRUN)
                holdPending <= 1'b0;
        end
    end

    // Register file; loss of core power wipes configuration
    always @(posedge mclk) begin
        if (rst) begin
            systemSetup <= `NSPM_RST_SYSTEM_SETUP;
            orientation <= `NSPM_RST_ORIENTATION;
        end else if (clkEn) begin
            if (state == ST_OFF || state == ST_POR) begin
                systemSetup <= `NSPM_RST_SYSTEM_SETUP;
                orientation <= `NSPM_RST_ORIENTATION;
            end else if (wr) begin
                if (regAddr == `NSPM_ADDR_SYSTEM_SETUP)
                    systemSetup <= regWdata;
                if (regAddr == `NSPM_ADDR_ORIENTATION)
                    orientation <= regWdata;
            end
            if (idleCmd)
                systemSetup[`NSPM_BIT_RUN_REQ] <= 1'b0;
        end
    end

    // Self-managed sleep after quiet frames; motion wakes at once
    always @(posedge mclk) begin
        if (rst) begin
            quietFrames <= 4'h0;
            selfSleep <= 1'b0;
        end else if (clkEn) begin
            if (state != ST_SRUN || motionSeen) begin
                quietFrames <= 4'h0;
                selfSleep <= 1'b0;
            end else if (frameEnd && !selfSleep) begin
                if (quietFrames == `NSPM_IDLE_FRAMES - 1)
                    selfSleep <= 1'b1;
                else
                    quietFrames <= quietFrames + 4'h1;
            end
        end
    end

    // Ready indication between boot and first run
    always @(posedge mclk) begin
        if (rst) begin
            flagReady <= 1'b0;
        end else if (clkEn) begin
            if (next_state == ST_IDLE && state == ST_BOOT)
                flagReady <= 1'b1;
            else if (next_state == ST_HRUN || next_state == ST_SRUN || next_state == ST_OFF)
                flagReady <= 1'b0;
        end
    end

    // Power and clock status, one cycle behind the state
    always @(posedge mclk) begin
        if (rst) begin
            powerState <= ST_OFF;
            corePowerOn <= 1'b0;
            coreClockRun <= 1'b0;
        end else if (clkEn) begin
            powerState <= state;
            corePowerOn <= (state != ST_OFF);
            coreClockRun <= ~(state == ST_OFF || state == ST_POR || state == ST_HOLD ||
                              (state == ST_SRUN && selfSleep));
        end
    end

    // Bus stays open in self sleep so the host can reach the device
    always @(posedge mclk) begin
        if (rst) begin
            engineEnable <= 1'b0;
            i2cEnable <= 1'b0;
        end else if (clkEn) begin
            engineEnable <= (state == ST_HRUN) | (state == ST_SRUN && !selfSleep);
            i2cEnable <= busOpen;
        end
    end

    // Movement flag level follows polarity and drive style
    always @(posedge mclk) begin
        if (rst) begin
            flagOut <= 1'b0;
            flagOe <= 1'b0;
        end else if (clkEn) begin
            if (flagReady) begin
                flagOut <= 1'b1;
                flagOe <= 1'b1;
            end else if (state == ST_HRUN || state == ST_SRUN || state == ST_HOLD) begin
                flagOut <= flagActive ^ actLow;
                flagOe <= openDrain ? ~(flagActive ^ actLow) : 1'b1;
            end else begin
                flagOut <= 1'b0;
                flagOe <= 1'b0;
            end
        end
    end

    // Read data one cycle after the address
    always @(posedge mclk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (clkEn) begin
            case (regAddr)
                `NSPM_ADDR_SYSTEM_SETUP: regRdata <= systemSetup;
                `NSPM_ADDR_ORIENTATION: regRdata <= orientation;
                `NSPM_ADDR_COMMAND: regRdata <= state;
                default: regRdata <= 8'h00;
            endcase
        end
    end

    // Per-axis source pick, then optional sign flip
    genvar axis;
    generate
        for (axis = 0; axis < 2; axis = axis + 1) begin : g_axis
            wire [7:0] src;
            wire [7:0] flipped;
            assign src = orientation[`NSPM_BIT_EXCHANGE] ? rawPair[8 * (1 - axis) +: 8] : rawPair[8 * axis +: 8];
            assign flipped = 8'h00 - src;
            assign orientedPair[8 * axis +: 8] = orientation[`NSPM_BIT_REV_X + axis] ? flipped : src;
        end
    endgenerate

    // Vectors held at zero while the engine is off
    always @(posedge mclk) begin
        if (rst) begin
            outDx <= 8'h00;
            outDy <= 8'h00;
        end else if (clkEn) begin
            if (engineEnable) begin
                outDx <= orientedPair[7:0];
                outDy <= orientedPair[15:8];
            end else begin
                outDx <= 8'h00;
                outDy <= 8'h00;
            end
        end
    end
endmodule // nspm_power_manager

// *** verification/nspm_checker_sva.sv ***
// Port checker of the power manager
module nspm_checker (
    input wire mclk,
    input wire rst,
    input wire clkEn,
    input wire holdPin,
    input wire supplyOffPin,
    input wire signed [7:0] outDx,
    input wire signed [7:0] outDy,
    input wire engineEnable,
    input wire i2cEnable,
    input wire coreClockRun,
    input wire corePowerOn,
    input wire [7:0] powerState
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_off: assert property (disable iff (1'b0) rst |=> powerState == 8'h01 && !corePowerOn)
        else $error("reset state wrong");
    a_state_onehot: assert property ($onehot(powerState))
        else $error("state not one-hot");
    a_supply_cut: assert property ((supplyOffPin && clkEn)[*6] |-> !corePowerOn)
        else $error("core power kept");
    a_engine_quiet: assert property (!engineEnable[*2] |-> outDx == 8'h00 && outDy == 8'h00)
        else $error("motion while engine off");
    a_hold_silent: assert property ((!coreClockRun && powerState != 8'h40)[*2] |-> !i2cEnable && !engineEnable)
        else $error("active without clock");
    // A clock stop in the hold state must follow a held pin; self-managed sleep stops are not checked
    a_stop_cause: assert property ($fell(coreClockRun) && powerState == 8'h80 |-> $past(holdPin, 2))
        else $error("clock stopped unasked");
    a_resume_fast: assert property ($fell(holdPin) && powerState == 8'h80 |-> ##[1:8] coreClockRun)
        else $error("slow resume");
    a_off_dark: assert property (!corePowerOn[*2] |-> !coreClockRun && !i2cEnable)
        else $error("alive without power");
endmodule // nspm_checker

bind nspm_power_manager nspm_checker i_chk (.mclk(mclk), .rst(rst), .clkEn(clkEn), .holdPin(holdPin),
    .supplyOffPin(supplyOffPin), .outDx(outDx), .outDy(outDy), .engineEnable(engineEnable),
    .i2cEnable(i2cEnable), .coreClockRun(coreClockRun), .corePowerOn(corePowerOn), .powerState(powerState));

// *** verification/nspm_host_model.sv ***
// Host driver of the hold and supply-off pins
module nspm_host_model #(
    parameter MIN_OFF = 40
) (
    input wire mclk,
    input wire holdReq,
    input wire offReq,
    output logic holdPin,
    output logic supplyOffPin
);
    timeunit 1ns;
    timeprecision 1ns;
    int offCnt = 0;
    initial holdPin = 1'b0;
    initial supplyOffPin = 1'b0;
    always @(posedge mclk) begin
        holdPin <= holdReq;
        // Short requests still give the full off time
        if (offReq) begin
            offCnt <= MIN_OFF;
        end else if (offCnt != 0) begin
            offCnt <= offCnt - 1;
        end
        supplyOffPin <= offReq || offCnt > 1;
    end
endmodule // nspm_host_model

// *** verification/nspm_power_manager_tb.sv ***
// Self-checking bench of the power manager
module nspm_power_manager_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst = 1'b1, regWrite = 1'b0, motionSeen = 1'b0, holdReq = 1'b0, offReq = 1'b0;
    logic clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, rawDx = 8'h05, rawDy = 8'hFD, regRdata, powerState, outDx, outDy;
    logic holdPin, supplyOffPin, flagOut, flagOe, i2cEnable, engineEnable, coreClockRun, corePowerOn;
    int errCount = 0, compares = 0, cyc = 0, n;
    logic [7:0] oc [4] = '{8'h00, 8'h01, 8'h02, 8'h08};
    logic [7:0] ex [4] = '{8'h05, 8'hFB, 8'h05, 8'hFD};
    logic [7:0] ey [4] = '{8'hFD, 8'hFD, 8'h03, 8'h05};
    nspm_power_manager #(.BOOT_CYC(50), .FRAME_CYC(20)) i_dut (.mclk(mclk), .rst(rst), .clkEn(clkEn),
        .holdPin(holdPin), .supplyOffPin(supplyOffPin), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .motionSeen(motionSeen), .rawDx(rawDx), .rawDy(rawDy),
        .outDx(outDx), .outDy(outDy), .flagOut(flagOut), .flagOe(flagOe), .i2cEnable(i2cEnable),
        .engineEnable(engineEnable), .coreClockRun(coreClockRun), .corePowerOn(corePowerOn),
        .powerState(powerState));
    nspm_host_model #(.MIN_OFF(40)) i_host (.mclk(mclk), .holdReq(holdReq), .offReq(offReq),
        .holdPin(holdPin), .supplyOffPin(supplyOffPin));
    initial forever #10 mclk = ~mclk;
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errCount++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge mclk);
        regAddr <= a;
        wt(2);
        chk(nm, e, regRdata);
    endtask
    task automatic pins(input logic h, input logic o, input logic m);
        @(posedge mclk);
        holdReq <= h;
        offReq <= o;
        motionSeen <= m;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        n = 0;
        while (flagOut !== 1'b1 && n < 1200) begin
            wt(1);
            n++;
        end
        chk("bootTime", 8'h01, 8'(n >= 1100 && n <= 1112));
        rd(8'h27, 8'h08, "orient");
        rd(8'h05, 8'h00, "setup");
        wr(8'h05, 8'h01);
        wt(3);
        chk("flagRun", 8'h00, flagOut);
        @(posedge mclk);
        clkEn <= 1'b0;
        wr(8'h27, 8'h00);
        wt(20);
        chk("frozenState", 8'h20, powerState);
        @(posedge mclk);
        clkEn <= 1'b1;
        rd(8'h27, 8'h08, "frozenWrite");
        for (int i = 0; i < 4; i++) begin
            wr(8'h27, oc[i]);
            wt(4);
            chk("outDx", ex[i], outDx);
            chk("outDy", ey[i], outDy);
        end
        pins(1'b1, 1'b0, 1'b0);
        wt(80);
        chk("holdIgnored", 8'h01, coreClockRun);
        wr(8'h05, 8'h11);
        n = 0;
        while (coreClockRun !== 1'b0 && n < 40) begin
            wt(1);
            n++;
        end
        chk("holdLatency", 8'h01, 8'(n <= 30));
        wr(8'h27, 8'h03);
        pins(1'b0, 1'b0, 1'b0);
        wt(10);
        chk("resume", 8'h01, coreClockRun);
        rd(8'h27, 8'h08, "orientKept");
        rd(8'h05, 8'h11, "setupKept");
        wr(8'h06, 8'h01);
        wt(3);
        chk("idleEngine", 8'h00, engineEnable);
        rd(8'h05, 8'h10, "runCleared");
        wr(8'h05, 8'h05);
        wt(3);
        chk("flagActLow", 8'h01, flagOut);
        wr(8'h06, 8'h01);
        wr(8'h05, 8'h0D);
        wt(3);
        chk("odRelease", 8'h00, flagOe);
        pins(1'b0, 1'b0, 1'b1);
        wt(5);
        chk("odDrive", 8'h02, {flagOe, flagOut});
        wr(8'h06, 8'h01);
        wr(8'h05, 8'h13);
        pins(1'b1, 1'b0, 1'b1);
        wt(6);
        chk("i2cOff", 8'h00, i2cEnable);
        wr(8'h27, 8'h00);
        pins(1'b0, 1'b0, 1'b1);
        wt(6);
        chk("i2cOn", 8'h01, i2cEnable);
        rd(8'h27, 8'h08, "csRefused");
        pins(1'b0, 1'b0, 1'b0);
        wt(200);
        chk("selfSleep", 8'h00, coreClockRun);
        chk("sleepEngine", 8'h00, engineEnable);
        chk("sleepBus", 8'h01, i2cEnable);
        pins(1'b0, 1'b0, 1'b1);
        wt(3);
        chk("wake", 8'h01, coreClockRun);
        pins(1'b0, 1'b1, 1'b1);
        pins(1'b0, 1'b0, 1'b1);
        wt(8);
        chk("powerOff", 8'h00, corePowerOn);
        wt(1300);
        chk("reboot", 8'h01, flagOut);
        rd(8'h05, 8'h00, "cfgLost");
        rd(8'h27, 8'h08, "orientReset");
        summarize();
    end
endmodule // nspm_power_manager_tb
